// ---- rtl/anx_pkg.sv ----
// Package holding register map, field positions, reset values and timing for link configuration.
package anx_pkg;
  // Register offsets on the management register port.
  localparam logic [4:0] OFF_BASIC_MODE_CONTROL = 5'h00;
  localparam logic [4:0] OFF_BASIC_STATUS       = 5'h01;
  localparam logic [4:0] OFF_ADVERTISED         = 5'h04;
  localparam logic [4:0] OFF_PARTNER            = 5'h05;
  localparam logic [4:0] OFF_EXPANSION          = 5'h06;
  localparam logic [4:0] OFF_PHY_LINK_STATUS    = 5'h10;
  localparam logic [4:0] OFF_CODING_SUBLAYER    = 5'h16;
  localparam logic [4:0] OFF_PHY_CONFIG         = 5'h19;
  // Basic mode control fields.
  localparam int BMC_SPEED   = 13;
  localparam int BMC_NEG_EN  = 12;
  localparam int BMC_RESTART = 9;
  localparam int BMC_DUPLEX  = 8;
  // Crossover control fields.
  localparam int PHC_AUTO_XOVER   = 15;
  localparam int PHC_FORCE_XOVER  = 14;
  localparam int CSC_FORCED_XOVER = 15;
  // Fixed status word: 100FD, 100HD, 10FD, 10HD, preamble suppression, negotiation able, extended.
  localparam logic [15:0] BASIC_STATUS_FIXED = 16'h7849;
  localparam logic [15:0] STATUS_COMPLETE    = 16'h0020;
  localparam logic [15:0] STATUS_REMOTE_FLT  = 16'h0010;
  localparam logic [15:0] STATUS_LINK        = 16'h0004;
  localparam logic [4:0]  SELECTOR_8023      = 5'h01;
  localparam logic [15:0] ADV_WRITE_MASK     = 16'hBFE0;
  localparam logic [15:0] PD_WORD_100        = 16'h0081;
  localparam logic [15:0] PD_WORD_10         = 16'h0021;
  localparam logic [15:0] PHY_CONFIG_RESET   = 16'h8000;
  localparam logic [15:0] CODING_RESET       = 16'h0000;
  localparam logic [15:0] LFSR_SEED          = 16'hACE1;
  // Timing.
  localparam int CLK_KHZ       = 100000;
  localparam int BREAK_LINK_MS = 1500;
  localparam int XOVER_SLOT_MS = 62;
  typedef enum logic [2:0] {ST_FORCED, ST_BREAK, ST_ABILITY, ST_WAIT_LINK, ST_COMPLETE} anx_state_t;
endpackage

// ---- rtl/anx_link_config.sv ----
// Negotiation, parallel detection and crossover control with its management registers.
module anx_link_config #(
  parameter int unsigned BREAK_CYCLES = anx_pkg::BREAK_LINK_MS * anx_pkg::CLK_KHZ,
  parameter int unsigned XOVER_SLOT   = anx_pkg::XOVER_SLOT_MS * anx_pkg::CLK_KHZ
) (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        negotiation_strap_enable,
  input  wire logic        ability_select_high,
  input  wire logic        ability_select_low,
  input  wire logic [4:0]  mgmt_addr,
  input  wire logic [15:0] mgmt_wdata,
  input  wire logic        mgmt_wr,
  input  wire logic        mgmt_rd,
  output logic      [15:0] mgmt_rdata,
  output logic             mgmt_rvalid,
  input  wire logic        link_10_good,
  input  wire logic        link_100_good,
  input  wire logic        link_pulse_seen,
  input  wire logic        partner_page_valid,
  input  wire logic [15:0] partner_page,
  output logic      [15:0] advertised_abilities_reg,
  output logic             flp_tx_enable,
  output logic             tx_halt,
  output logic             speed_100,
  output logic             full_duplex,
  output logic             nego_complete,
  output logic             crossover
);
  anx_pkg::anx_state_t st_reg, st_next;
  logic [15:0] partner_abilities_reg, coding_sublayer_config_reg, phy_config_reg;
  logic        spd_reg, dup_reg, en_reg, armed_reg, restart_reg;
  logic        lp_able_reg, page_rx_reg, pdf_reg, pd_reg;
  logic [31:0] brk_cnt_reg, slot_cnt_reg;
  logic [15:0] lfsr_reg;

  // Strap decode, only consumed while srst is high.
  wire [1:0]  strap_sel = {ability_select_high, ability_select_low};
  wire [3:0]  strap_adv = !negotiation_strap_enable ? 4'hF :
                          (strap_sel == 2'b00) ? 4'h3 :
                          (strap_sel == 2'b01) ? 4'hC :
                          (strap_sel == 2'b10) ? 4'h8 : 4'hF;
  wire        strap_spd = negotiation_strap_enable | ability_select_high;
  wire        strap_dup = negotiation_strap_enable | ability_select_low;

  // Register decode.
  wire wr_bmc  = mgmt_wr && mgmt_addr == anx_pkg::OFF_BASIC_MODE_CONTROL;
  wire wr_adv  = mgmt_wr && mgmt_addr == anx_pkg::OFF_ADVERTISED;
  wire wr_csc  = mgmt_wr && mgmt_addr == anx_pkg::OFF_CODING_SUBLAYER;
  wire wr_phc  = mgmt_wr && mgmt_addr == anx_pkg::OFF_PHY_CONFIG;
  wire rd_exp  = mgmt_rd && mgmt_addr == anx_pkg::OFF_EXPANSION;

  // A strapped-forced part only negotiates after enable was seen clear and then set.
  wire an_active = en_reg && armed_reg;

  // Priority resolution over the common ability set.
  wire [3:0] common  = advertised_abilities_reg[8:5] & partner_page[8:5];
  wire       res_spd = common[3] | common[2];
  wire       res_dup = common[3] | (~common[2] & common[1]);
  // Link check follows the resolved mode; the speed control bit is ignored while negotiating.
  wire       res_link = speed_100 ? link_100_good : link_10_good;
  wire       pd_one  = link_10_good ^ link_100_good;
  wire       pd_both = link_10_good & link_100_good;
  wire       in_ability = st_reg == anx_pkg::ST_ABILITY;
  wire       page_in = in_ability && partner_page_valid;
  wire       pd_done = in_ability && !partner_page_valid && !lp_able_reg && pd_one;
  wire       pdf_set = in_ability && !lp_able_reg && pd_both;
  wire       brk_done = brk_cnt_reg == BREAK_CYCLES - 1;

  always_comb begin
    st_next = st_reg;
    if (st_reg != anx_pkg::ST_FORCED && !an_active) begin
      st_next = anx_pkg::ST_FORCED;
    end else if (restart_reg && an_active && st_reg != anx_pkg::ST_BREAK) begin
      st_next = anx_pkg::ST_BREAK;
    end else begin
      unique case (st_reg)
        anx_pkg::ST_FORCED:    if (an_active) st_next = anx_pkg::ST_BREAK;
        anx_pkg::ST_BREAK:     if (brk_done) st_next = anx_pkg::ST_ABILITY;
        anx_pkg::ST_ABILITY: begin
          if (page_in && common != 4'h0) st_next = anx_pkg::ST_WAIT_LINK;
          else if (pd_done) st_next = anx_pkg::ST_COMPLETE;
        end
        anx_pkg::ST_WAIT_LINK: if (res_link) st_next = anx_pkg::ST_COMPLETE;
        anx_pkg::ST_COMPLETE:  if (!res_link) st_next = anx_pkg::ST_ABILITY;
      endcase
    end
  end

  // Crossover hunting: stops once pulses or 100 Mb/s signalling show up.
  wire quiet    = !link_pulse_seen && !link_100_good && !lp_able_reg;
  wire hunt_an  = phy_config_reg[anx_pkg::PHC_AUTO_XOVER] && an_active &&
                  st_reg != anx_pkg::ST_COMPLETE && quiet;
  wire hunt_fm  = coding_sublayer_config_reg[anx_pkg::CSC_FORCED_XOVER] &&
                  !an_active && quiet;
  wire slot_end = slot_cnt_reg == XOVER_SLOT - 1;
  wire lfsr_fb  = lfsr_reg[15] ^ lfsr_reg[13] ^ lfsr_reg[12] ^ lfsr_reg[10];

  // Read selection; unmapped offsets read zero.
  wire [15:0] basic_status = anx_pkg::BASIC_STATUS_FIXED |
    (nego_complete ? anx_pkg::STATUS_COMPLETE : 16'h0000) |
    (partner_abilities_reg[13] ? anx_pkg::STATUS_REMOTE_FLT : 16'h0000) |
    (nego_complete && res_link ? anx_pkg::STATUS_LINK : 16'h0000);
  wire [15:0] bmc_view = {2'b00, spd_reg, en_reg, 2'b00, restart_reg, dup_reg, 8'h00};
  wire [15:0] exp_view = {11'h000, pdf_reg, partner_abilities_reg[15], 1'b0,
                          page_rx_reg, lp_able_reg};
  wire [15:0] sts_view = {13'h0000, full_duplex, !speed_100, nego_complete && res_link};
  wire [15:0] rd_mux =
    (mgmt_addr == anx_pkg::OFF_BASIC_MODE_CONTROL) ? bmc_view :
    (mgmt_addr == anx_pkg::OFF_BASIC_STATUS)       ? basic_status :
    (mgmt_addr == anx_pkg::OFF_ADVERTISED)         ? advertised_abilities_reg :
    (mgmt_addr == anx_pkg::OFF_PARTNER)            ? partner_abilities_reg :
    (mgmt_addr == anx_pkg::OFF_EXPANSION)          ? exp_view :
    (mgmt_addr == anx_pkg::OFF_PHY_LINK_STATUS)    ? sts_view :
    (mgmt_addr == anx_pkg::OFF_CODING_SUBLAYER)    ? coding_sublayer_config_reg :
    (mgmt_addr == anx_pkg::OFF_PHY_CONFIG)         ? phy_config_reg : 16'h0000;

  // Straps are taken only while srst is high; afterwards only writes change the setup.
  always_ff @(posedge clk) begin
    if (srst) begin
      en_reg    <= negotiation_strap_enable;
      armed_reg <= negotiation_strap_enable;
      spd_reg   <= strap_spd;
      dup_reg   <= strap_dup;
      advertised_abilities_reg <= {7'h00, strap_adv, anx_pkg::SELECTOR_8023};
    end else begin
      if (wr_bmc) begin
        en_reg    <= mgmt_wdata[anx_pkg::BMC_NEG_EN];
        armed_reg <= armed_reg | ~mgmt_wdata[anx_pkg::BMC_NEG_EN];
        spd_reg   <= mgmt_wdata[anx_pkg::BMC_SPEED];
        dup_reg   <= mgmt_wdata[anx_pkg::BMC_DUPLEX];
      end
      if (wr_adv) begin
        advertised_abilities_reg <= (mgmt_wdata & anx_pkg::ADV_WRITE_MASK) |
                                    {11'h000, anx_pkg::SELECTOR_8023};
      end
    end
  end

  // Restart is a self-clearing request; a write in the clearing cycle still wins.
  always_ff @(posedge clk) begin
    if (srst) begin
      restart_reg <= 1'b0;
    end else if (wr_bmc && mgmt_wdata[anx_pkg::BMC_RESTART]) begin
      restart_reg <= 1'b1;
    end else if (st_next == anx_pkg::ST_BREAK || st_reg == anx_pkg::ST_FORCED) begin
      restart_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_reg      <= anx_pkg::ST_FORCED;
      brk_cnt_reg <= 32'h0000_0000;
    end else begin
      st_reg      <= st_next;
      brk_cnt_reg <= (st_next == anx_pkg::ST_BREAK && st_reg == anx_pkg::ST_BREAK) ?
                     brk_cnt_reg + 32'h0000_0001 : 32'h0000_0000;
    end
  end

  // A lost link starts a fresh exchange, so stale partner data cannot block parallel detection.
  wire link_lost = st_reg == anx_pkg::ST_COMPLETE && st_next == anx_pkg::ST_ABILITY;

  // Partner word, expansion flags and the parallel-detect marker.
  always_ff @(posedge clk) begin
    if (srst) begin
      partner_abilities_reg <= 16'h0000;
      lp_able_reg <= 1'b0;
      pd_reg      <= 1'b0;
    end else if (st_reg == anx_pkg::ST_BREAK || link_lost) begin
      partner_abilities_reg <= 16'h0000;
      lp_able_reg <= 1'b0;
      pd_reg      <= 1'b0;
    end else if (page_in) begin
      partner_abilities_reg <= partner_page;
      lp_able_reg <= 1'b1;
    end else if (pd_done) begin
      partner_abilities_reg <= link_100_good ? anx_pkg::PD_WORD_100 :
                                               anx_pkg::PD_WORD_10;
      pd_reg      <= 1'b1;
    end
  end

  // Sticky flags clear on an expansion read; a new event in that cycle wins.
  always_ff @(posedge clk) begin
    if (srst) begin
      page_rx_reg <= 1'b0;
      pdf_reg     <= 1'b0;
    end else begin
      page_rx_reg <= page_in | (page_rx_reg & ~rd_exp);
      pdf_reg     <= pdf_set | (pdf_reg & ~rd_exp);
    end
  end

  // Resolved operating mode and link-facing outputs.
  always_ff @(posedge clk) begin
    if (srst) begin
      speed_100     <= 1'b0;
      full_duplex   <= 1'b0;
      nego_complete <= 1'b0;
      tx_halt       <= 1'b0;
      flp_tx_enable <= 1'b0;
    end else begin
      if (st_reg == anx_pkg::ST_FORCED) begin
        speed_100   <= spd_reg;
        full_duplex <= dup_reg;
      end else if (page_in && common != 4'h0) begin
        speed_100   <= res_spd;
        full_duplex <= res_dup;
      end else if (pd_done) begin
        speed_100   <= link_100_good;
        full_duplex <= 1'b0;
      end
      nego_complete <= st_reg == anx_pkg::ST_COMPLETE;
      tx_halt       <= st_reg == anx_pkg::ST_BREAK;
      flp_tx_enable <= in_ability;
    end
  end

  // Forcing wins over hunting, so software can pin the pairs whatever the link does.

  always_ff @(posedge clk) begin
    if (srst) begin
      coding_sublayer_config_reg <= anx_pkg::CODING_RESET;
      phy_config_reg <= anx_pkg::PHY_CONFIG_RESET;
      lfsr_reg       <= anx_pkg::LFSR_SEED;
      slot_cnt_reg   <= 32'h0000_0000;
      crossover      <= 1'b0;
    end else begin
      if (wr_csc) coding_sublayer_config_reg <= mgmt_wdata;
      if (wr_phc) phy_config_reg <= mgmt_wdata;
      lfsr_reg     <= {lfsr_reg[14:0], lfsr_fb};
      slot_cnt_reg <= slot_end ? 32'h0000_0000 : slot_cnt_reg + 32'h0000_0001;
      if (phy_config_reg[anx_pkg::PHC_FORCE_XOVER]) begin
        crossover <= 1'b1;
      end else if (slot_end && (hunt_an || hunt_fm)) begin
        crossover <= lfsr_reg[0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      mgmt_rdata  <= 16'h0000;
      mgmt_rvalid <= 1'b0;
    end else begin
      mgmt_rdata  <= mgmt_rd ? rd_mux : mgmt_rdata;
      mgmt_rvalid <= mgmt_rd;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  a_strap_forced: assert property ($fell(srst) && !$past(negotiation_strap_enable) |->
    !en_reg && spd_reg == $past(ability_select_high) && dup_reg == $past(ability_select_low))
    else $error("forced strap not decoded");
  a_strap_adv: assert property ($fell(srst) && $past(negotiation_strap_enable) &&
    $past(strap_sel) == 2'b10 |-> advertised_abilities_reg[8:5] == 4'h8)
    else $error("advertised strap bits wrong");
  a_forced_speed: assert property ((st_reg == anx_pkg::ST_FORCED && !srst)[*2] |->
    speed_100 == $past(spd_reg) && full_duplex == $past(dup_reg))
    else $error("forced speed not followed");
  a_break_halt: assert property ($rose(st_reg == anx_pkg::ST_BREAK) |=>
    tx_halt && !flp_tx_enable) else $error("break does not halt transmit");
  a_restart_go: assert property (wr_bmc && mgmt_wdata[anx_pkg::BMC_RESTART] &&
    mgmt_wdata[anx_pkg::BMC_NEG_EN] && an_active && st_reg == anx_pkg::ST_COMPLETE |->
    ##2 st_reg == anx_pkg::ST_BREAK) else $error("restart ignored");
  a_pd_word: assert property (pd_done && link_100_good |=>
    partner_abilities_reg == anx_pkg::PD_WORD_100) else $error("parallel word wrong");
  a_pd_able: assert property (st_reg == anx_pkg::ST_COMPLETE && pd_reg |->
    !lp_able_reg) else $error("partner able set after parallel detect");
  a_link_loss: assert property (st_reg == anx_pkg::ST_COMPLETE && !res_link && an_active &&
    !restart_reg |=> st_reg == anx_pkg::ST_ABILITY) else $error("no renegotiation on loss");
  a_force_xover: assert property (phy_config_reg[anx_pkg::PHC_FORCE_XOVER] |=>
    crossover) else $error("forced crossover not applied");
  a_prio_top: assert property (page_in && common == 4'hF |=>
    speed_100 && full_duplex) else $error("priority resolution wrong");
  a_pd_fault: assert property (pdf_set |=> pdf_reg) else $error("detect fault lost");

  c_break_end: cover property (st_reg == anx_pkg::ST_BREAK ##1 st_reg == anx_pkg::ST_ABILITY);
  c_neg_done: cover property (st_reg == anx_pkg::ST_WAIT_LINK ##1 st_reg == anx_pkg::ST_COMPLETE);
  c_pd_done: cover property (pd_done ##1 st_reg == anx_pkg::ST_COMPLETE);
  c_xover_hunt: cover property (hunt_fm && slot_end);
endmodule

// ---- dv/anx_partner_model.sv ----
// Behavioural link partner on the cable side of the link configuration block.
module anx_partner_model (
  input  wire logic        clk,
  input  wire logic [2:0]  mode,
  input  wire logic        fast,
  input  wire logic [15:0] page_word,
  input  wire logic        flp_tx_enable,
  input  wire logic        tx_halt,
  output logic             link_10_good,
  output logic             link_100_good,
  output logic             link_pulse_seen,
  output logic             partner_page_valid,
  output logic      [15:0] partner_page
);
  timeunit 1ns;
  timeprecision 1ps;
  // Modes: 0 silent, 1 negotiating, 2 lone 100, 3 lone 10, 4 both receivers good.
  logic flp_q = 1'b0;
  logic got   = 1'b0;
  // One code word per burst window, as a real partner answers each new burst.
  always @(posedge clk) begin
    flp_q <= flp_tx_enable;
    partner_page_valid <= (mode == 3'h1) && flp_tx_enable && !flp_q;
    if (mode != 3'h1 || tx_halt) begin
      got <= 1'b0;
    end else if (partner_page_valid) begin
      got <= 1'b1;
    end
  end
  // Outside a valid strobe the word is inverted, so stale data never looks fresh.
  assign partner_page = partner_page_valid ? page_word : ~page_word;
  assign link_100_good = (mode == 3'h1 && got && fast) || mode == 3'h2 || mode == 3'h4;
  assign link_10_good = (mode == 3'h1 && got && !fast) || mode == 3'h3 || mode == 3'h4;
  assign link_pulse_seen = mode != 3'h0;
endmodule

// ---- dv/tb.sv ----
// Self-checking testbench for the link configuration block.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, srst = 1'b1, s_en = 1'b0, s_hi = 1'b0, s_lo = 1'b0;
  logic [4:0] mgmt_addr = 5'h00;
  logic [15:0] mgmt_wdata = 16'h0000, mgmt_rdata, adv, v;
  logic mgmt_wr = 1'b0, mgmt_rd = 1'b0, mgmt_rvalid;
  logic l10, l100, lps, pvalid, flp, halt, spd, fdx, done, xo, fast = 1'b1, x0;
  logic [15:0] ppage;
  logic [2:0] mode = 3'h0;
  int error_cnt = 0, total_checks = 0, n;
  logic [15:0] adv_tab [4] = '{16'h0061, 16'h0181, 16'h0101, 16'h01E1};
  always #5 clk = ~clk;
  anx_link_config #(.BREAK_CYCLES(20), .XOVER_SLOT(8)) uut (
    .clk(clk), .srst(srst), .negotiation_strap_enable(s_en), .ability_select_high(s_hi),
    .ability_select_low(s_lo), .mgmt_addr(mgmt_addr), .mgmt_wdata(mgmt_wdata),
    .mgmt_wr(mgmt_wr), .mgmt_rd(mgmt_rd), .mgmt_rdata(mgmt_rdata), .mgmt_rvalid(mgmt_rvalid),
    .link_10_good(l10), .link_100_good(l100), .link_pulse_seen(lps),
    .partner_page_valid(pvalid), .partner_page(ppage), .advertised_abilities_reg(adv),
    .flp_tx_enable(flp), .tx_halt(halt), .speed_100(spd), .full_duplex(fdx),
    .nego_complete(done), .crossover(xo));
  anx_partner_model partner (.clk(clk), .mode(mode), .fast(fast), .page_word(16'h01E1),
    .flp_tx_enable(flp), .tx_halt(halt), .link_10_good(l10), .link_100_good(l100),
    .link_pulse_seen(lps), .partner_page_valid(pvalid), .partner_page(ppage));
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    mgmt_wr <= 1'b1;
    mgmt_addr <= a;
    mgmt_wdata <= d;
    @(posedge clk);
    mgmt_wr <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(posedge clk);
    mgmt_rd <= 1'b1;
    mgmt_addr <= a;
    @(posedge clk);
    mgmt_rd <= 1'b0;
    #1;
    chk("read valid", 16'h0001, {15'h0000, mgmt_rvalid});
    d = mgmt_rdata;
  endtask
  // Bounded wait for one of the block's level outputs: 0 bursts, 1 complete, 2 halt.
  task automatic wt(input int sel);
    for (n = 0; n < 400; n++) begin
      @(posedge clk);
      #1;
      if ((sel == 0 && flp === 1'b1) || (sel == 1 && done === 1'b1) ||
          (sel == 2 && halt === 1'b1)) break;
    end
    chk("wait bound", 16'h0000, {15'h0000, n >= 400});
  endtask
  task automatic do_reset(input logic e, input logic h, input logic l);
    @(posedge clk);
    srst <= 1'b1;
    s_en <= e;
    s_hi <= h;
    s_lo <= l;
    repeat (20) @(posedge clk);
    srst <= 1'b0;
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    summarize();
  end
  initial begin
    for (int i = 0; i < 4; i++) begin
      do_reset(1'b0, i[1], i[0]);
      @(posedge clk);
      s_hi <= ~s_hi;
      s_lo <= ~s_lo;
      repeat (3) @(posedge clk);
      chk("forced speed", {15'h0000, i[1]}, {15'h0000, spd});
      chk("forced duplex", {15'h0000, i[0]}, {15'h0000, fdx});
      do_reset(1'b1, i[1], i[0]);
      repeat (2) @(posedge clk);
      rd(anx_pkg::OFF_ADVERTISED, v);
      chk("strap advert", adv_tab[i], v);
    end
    rd(anx_pkg::OFF_BASIC_STATUS, v);
    chk("basic status", 16'h7849, v);
    rd(anx_pkg::OFF_PHY_CONFIG, v);
    chk("phy config", 16'h8000, v);
    rd(anx_pkg::OFF_CODING_SUBLAYER, v);
    chk("coding", 16'h0000, v);
    rd(5'h1F, v);
    chk("unmapped", 16'h0000, v);
    mode <= 3'h1;
    wt(2);
    chk("bursts in break", 16'h0000, {15'h0000, flp});
    wt(0);
    wt(1);
    chk("neg speed", 16'h0001, {15'h0000, spd});
    chk("neg duplex", 16'h0001, {15'h0000, fdx});
    rd(anx_pkg::OFF_PARTNER, v);
    chk("partner word", 16'h01E1, v);
    rd(anx_pkg::OFF_EXPANSION, v);
    chk("expansion after page", 16'h0003, v);
    wr(anx_pkg::OFF_ADVERTISED, 16'h0060);
    rd(anx_pkg::OFF_ADVERTISED, v);
    chk("restricted advert", 16'h0061, v);
    chk("advert port", 16'h0061, adv);
    wr(anx_pkg::OFF_BASIC_MODE_CONTROL, 16'h1200);
    fast <= 1'b0;
    wt(2);
    chk("bursts halted", 16'h0000, {15'h0000, flp});
    wt(0);
    wt(1);
    chk("ten speed", 16'h0000, {15'h0000, spd});
    chk("ten duplex", 16'h0001, {15'h0000, fdx});
    mode <= 3'h0;
    wt(0);
    chk("resume no halt", 16'h0000, {15'h0000, halt | done});
    mode <= 3'h2;
    wt(1);
    chk("pd speed", 16'h0001, {15'h0000, spd});
    rd(anx_pkg::OFF_PARTNER, v);
    chk("pd word 100", 16'h0081, v);
    rd(anx_pkg::OFF_EXPANSION, v);
    chk("pd not able", 16'h0000, v & 16'h0001);
    rd(anx_pkg::OFF_BASIC_STATUS, v);
    chk("pd complete", 16'h0020, v & 16'h0020);
    mode <= 3'h0;
    wt(0);
    mode <= 3'h3;
    wt(1);
    rd(anx_pkg::OFF_PARTNER, v);
    chk("pd word 10", 16'h0021, v);
    mode <= 3'h0;
    wt(0);
    mode <= 3'h4;
    repeat (5) @(posedge clk);
    rd(anx_pkg::OFF_EXPANSION, v);
    chk("detect fault", 16'h0010, v & 16'h0010);
    mode <= 3'h0;
    wr(anx_pkg::OFF_BASIC_MODE_CONTROL, 16'h2000);
    repeat (3) @(posedge clk);
    chk("bit speed", 16'h0001, {15'h0000, spd});
    chk("bit duplex", 16'h0000, {15'h0000, fdx});
    wr(anx_pkg::OFF_PHY_CONFIG, 16'h4000);
    repeat (3) @(posedge clk);
    chk("forced cross", 16'h0001, {15'h0000, xo});
    wr(anx_pkg::OFF_PHY_CONFIG, 16'h0000);
    wr(anx_pkg::OFF_CODING_SUBLAYER, 16'h8000);
    n = 0;
    x0 = xo;
    repeat (300) begin
      @(posedge clk);
      if (xo !== x0) n++;
      x0 = xo;
    end
    chk("hunting", 16'h0001, {15'h0000, n > 0});
    mode <= 3'h2;
    repeat (20) @(posedge clk);
    n = 0;
    x0 = xo;
    repeat (100) begin
      @(posedge clk);
      if (xo !== x0) n++;
    end
    chk("hunt stops", 16'h0000, n[15:0]);
    do_reset(1'b0, 1'b0, 1'b0);
    repeat (2) @(posedge clk);
    chk("strap forced advert", 16'h01E1, adv);
    wr(anx_pkg::OFF_BASIC_MODE_CONTROL, 16'h1000);
    repeat (5) @(posedge clk);
    chk("enable without clear", 16'h0000, {15'h0000, halt | flp});
    wr(anx_pkg::OFF_BASIC_MODE_CONTROL, 16'h0000);
    wr(anx_pkg::OFF_BASIC_MODE_CONTROL, 16'h1000);
    wt(2);
    summarize();
  end
endmodule
